// [dv/gpm_host_model.sv]
module gpm_host_model #(
  parameter int CMD_HOLD = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic insert_req,
  input wire logic wake_req,
  output logic battery_present_pin,
  output logic ext_supply_pin,
  output logic addressed_cmd_pin
);
  logic wake_q;
  int hold_q;
  // adapter stays attached, so a removed pack leaves the gauge powered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
      hold_q <= 0;
      battery_present_pin <= 1'b0;
      ext_supply_pin <= 1'b1;
    end else begin
      wake_q <= wake_req;
      battery_present_pin <= insert_req;
      ext_supply_pin <= 1'b1;
      if (wake_req && !wake_q) begin
        hold_q <= CMD_HOLD;
      end else if (hold_q > 0) begin
        hold_q <= hold_q - 1;
      end
    end
  end
  // held several cycles so the synchroniser cannot miss it
  assign addressed_cmd_pin = (hold_q > 0);
endmodule

// [dv/gpm_top_tb.sv]
module gpm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INS = 20;
  localparam int DZP = 8;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st, d0;
  logic pready, pslverr, bat_pin, sup_pin, cmd_pin;
  logic signed [15:0] shunt_uv;
  logic good, strobe, halted, ocv_req, flash_ok, prof;
  logic insert_req, wake_req, saw_cal;
  int bad_count, total_checks, ocv_cnt, strobe_cnt, polls;

  gpm_top #(.INSERT_CYCLES(INS), .DOZE_PERIOD(DZP), .TEMP_PERSIST(50)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .battery_present_pin(bat_pin),
    .ext_supply_pin(sup_pin), .addressed_cmd_pin(cmd_pin),
    .shunt_uv(shunt_uv), .battery_good_output(good),
    .measure_strobe(strobe), .core_halted(halted), .ocv_request(ocv_req),
    .flash_write_ok(flash_ok), .profile_select(prof));

  gpm_host_model u_host (
    .pclk(pclk), .presetn(presetn), .insert_req(insert_req),
    .wake_req(wake_req), .battery_present_pin(bat_pin),
    .ext_supply_pin(sup_pin), .addressed_cmd_pin(cmd_pin));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (ocv_req === 1'b1) ocv_cnt++;
    if (strobe === 1'b1) strobe_cnt++;
  end

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one transfer; read data lands in st at the completing edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    st = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_mode(input logic [2:0] m);
    polls = 0;
    saw_cal = 1'b0;
    do begin
      apb(1'b0, gpm_pkg::OFF_STATUS, 32'h0);
      polls++;
      if (st[2:0] === 3'd1) saw_cal = 1'b1;
    end while (st[2:0] !== m && polls < 100);
    check("mode", st[2:0], m);
  endtask

  task test_reset;
    check("halted", halted, 1);
    check("good", good, 0);
    apb(1'b0, gpm_pkg::OFF_CONFIG, 32'h0);
    check("config", st, 32'h0000_0013);
    apb(1'b0, gpm_pkg::OFF_DOZE_THR, 32'h0);
    check("doze_thr", st, 32'h0000_000A);
    apb(1'b0, gpm_pkg::OFF_REST_THR, 32'h0);
    check("rest_thr", st, 32'h0000_0005);
    apb(1'b0, gpm_pkg::OFF_FLASH_THR, 32'h0);
    check("flash_thr", st, 32'h0000_0C80);
    apb(1'b0, 12'hFFC, 32'h0);
    check("unmapped", st, 32'h0);
    apb(1'b1, gpm_pkg::OFF_MEAS_V, 32'h0000_0E74);
    apb(1'b1, gpm_pkg::OFF_MEAS_I, 32'h0000_0032);
    apb(1'b1, gpm_pkg::OFF_MEAS_T, 32'h0000_0019);
  endtask

  task test_insert;
    int n;
    n = 0;
    insert_req <= 1'b1;
    while (halted !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    check("ins_lo", n >= INS, 1);
    check("ins_hi", n <= INS + 8, 1);
    wait_mode(3'd0);
    check("ocv_valid", st[6], 1);
    check("good", good, 1);
    check("ocv", ocv_cnt, 1);
    check("profile", prof, 1);
    apb(1'b1, gpm_pkg::OFF_MEAS_V, 32'h0000_0C7F);
    @(negedge pclk);
    check("flash_lo", flash_ok, 0);
    apb(1'b1, gpm_pkg::OFF_MEAS_V, 32'h0000_0C80);
    @(negedge pclk);
    check("flash_hi", flash_ok, 1);
  endtask

  task test_doze;
    apb(1'b1, gpm_pkg::OFF_MEAS_I, 32'h0000_0005);
    wait_mode(3'd2);
    check("cal_seen", saw_cal, 1);
    check("cal_len", polls >= 18, 1);
    strobe_cnt = 0;
    repeat (4 * DZP) @(posedge pclk);
    check("strobes", strobe_cnt inside {[3:5]}, 1);
    // both polarities of sense voltage must trip the comparator
    for (int k = 0; k < 2; k++) begin
      shunt_uv <= (k == 0) ? 16'hFBB4 : 16'h044C;
      polls = 0;
      do begin
        apb(1'b0, gpm_pkg::OFF_STATUS, 32'h0);
        polls++;
      end while (st[2:0] === 3'd2 && polls < 20);
      check("woke", st[2:0] !== 3'd2, 1);
      shunt_uv <= 16'h0000;
      wait_mode(3'd2);
    end
    apb(1'b1, gpm_pkg::OFF_CONFIG, 32'h0000_0011);
    shunt_uv <= 16'hFBB4;
    repeat (20) @(posedge pclk);
    apb(1'b0, gpm_pkg::OFF_STATUS, 32'h0);
    check("cmp_off", st[2:0], 3'd2);
    shunt_uv <= 16'h0000;
    apb(1'b1, gpm_pkg::OFF_CONFIG, 32'h0000_0013);
    apb(1'b1, gpm_pkg::OFF_MEAS_I, 32'h0000_0014);
    wait_mode(3'd0);
    apb(1'b1, gpm_pkg::OFF_MEAS_T, 32'h0000_002D);
    apb(1'b1, gpm_pkg::OFF_MEAS_I, 32'h0000_0005);
    wait_mode(3'd2);
    check("no_cal", saw_cal, 0);
    apb(1'b1, gpm_pkg::OFF_MEAS_I, 32'h0000_0014);
    wait_mode(3'd0);
  endtask

  task test_rest;
    apb(1'b1, gpm_pkg::OFF_MEAS_V, 32'h0000_0004);
    wait_mode(3'd5);
    check("rest_good", good, 0);
    repeat (20) @(posedge pclk);
    apb(1'b1, gpm_pkg::OFF_MEAS_V, 32'h0000_0E74);
    apb(1'b0, gpm_pkg::OFF_STATUS, 32'h0);
    check("stay_rest", st[2:0], 3'd5);
    wake_req <= 1'b1;
    wait_mode(3'd0);
    wake_req <= 1'b0;
    check("ocv2", ocv_cnt, 2);
    check("profile2", prof, 0);
    check("good2", good, 1);
  endtask

  task test_remove_reset;
    int n;
    n = 0;
    insert_req <= 1'b0;
    while (halted !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    check("remove", n <= 6, 1);
    wait_mode(3'd3);
    apb(1'b0, gpm_pkg::OFF_CHECKSUM, 32'h0);
    d0 = st;
    apb(1'b1, gpm_pkg::OFF_CONTROL, 32'h1234_0008);
    apb(1'b0, gpm_pkg::OFF_CHECKSUM, 32'h0);
    check("sum", st[15:0], d0[15:0] + 16'h1234);
    d0 = st;
    apb(1'b1, gpm_pkg::OFF_CONTROL, 32'h0000_0006);
    repeat (4) @(posedge pclk);
    apb(1'b0, gpm_pkg::OFF_CHECKSUM, 32'h0);
    check("sum_kept", st, d0);
    apb(1'b1, gpm_pkg::OFF_CONTROL, 32'h0000_0002);
    repeat (4) @(posedge pclk);
    apb(1'b0, gpm_pkg::OFF_RST_CNT, 32'h0);
    check("rst_cnt", st[15:0], 16'h0101);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    shunt_uv = 16'h0000;
    insert_req = 1'b0;
    wake_req = 1'b0;
    bad_count = 0;
    total_checks = 0;
    ocv_cnt = 0;
    strobe_cnt = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    test_reset;
    test_insert;
    test_doze;
    test_rest;
    test_remove_reset;
    wrap_up;
  end

  // whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    wrap_up;
  end
endmodule

// [src/gpm_pkg.sv]
package gpm_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int INSERT_US = 3000;
  localparam int INSERT_CYC = (CLK_HZ / 1_000_000) * INSERT_US;
  localparam int DOZE_PERIOD_US = 1000;
  localparam int DOZE_PERIOD_CYC = (CLK_HZ / 1_000_000) * DOZE_PERIOD_US;
  localparam int TEMP_PERSIST_S = 60;
  localparam int TEMP_PERSIST_CYC = CLK_HZ * TEMP_PERSIST_S;
  localparam int CAL_CYC = 64;
  // register byte offsets
  localparam logic [11:0] OFF_CONFIG = 12'h000;
  localparam logic [11:0] OFF_DOZE_THR = 12'h004;
  localparam logic [11:0] OFF_REST_THR = 12'h008;
  localparam logic [11:0] OFF_FLASH_THR = 12'h00C;
  localparam logic [11:0] OFF_MEAS_I = 12'h010;
  localparam logic [11:0] OFF_MEAS_V = 12'h014;
  localparam logic [11:0] OFF_MEAS_T = 12'h018;
  localparam logic [11:0] OFF_CONTROL = 12'h01C;
  localparam logic [11:0] OFF_STATUS = 12'h020;
  localparam logic [11:0] OFF_RST_CNT = 12'h024;
  localparam logic [11:0] OFF_OFFSET = 12'h028;
  localparam logic [11:0] OFF_CHECKSUM = 12'h02C;
  // config fields
  localparam int CFG_DOZE_EN = 0;
  localparam int CFG_SNS_LOW = 1;
  localparam int CFG_SNS_HIGH = 2;
  localparam int CFG_WAKE_RANGE = 3;
  localparam int CFG_GOOD_POL = 4;
  // control fields
  localparam int CTL_REST_REQ = 0;
  localparam int CTL_SW_RESET = 1;
  localparam int CTL_RESET_PARTIAL = 2;
  localparam int CTL_MEM_WRITE = 3;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0013;
  localparam logic [15:0] DOZE_THR_RST = 16'h000A;
  localparam logic [15:0] REST_THR_RST = 16'h0005;
  localparam logic [15:0] FLASH_THR_RST = 16'h0C80;
  localparam logic [15:0] CAL_I_MAX_MA = 16'h0064;
  localparam logic [15:0] CAL_DV_MV = 16'h0100;
  localparam logic [15:0] CAL_ABORT_MV = 16'h0020;
  localparam logic signed [15:0] T_LOW_C = 16'sh0005;
  localparam logic signed [15:0] T_SKIP_C = 16'sh002D;
  // wake thresholds in microvolts
  localparam logic [15:0] VTH_1P0 = 16'h03E8;
  localparam logic [15:0] VTH_2P2 = 16'h0898;
  localparam logic [15:0] VTH_4P6 = 16'h11F8;
  localparam logic [15:0] VTH_9P8 = 16'h2648;
  typedef enum logic [2:0] {
    GPM_NORMAL, GPM_CAL, GPM_DOZE, GPM_INSERT_WAIT, GPM_INIT, GPM_REST
  } gpm_mode_t;
endpackage

// [src/gpm_top.sv]
// Contract
// [RULE1] doze only if enabled and current low
// [RULE2] autocalibrate after qualifying, before doze
// [RULE3] doze wakes periodically to measure
// [RULE4] leave doze on current rise or wake
// [RULE5] battery removed on supply: go insertion-wait; the code goes via normal from doze and never checks removal in rest
// [RULE6] insertion-wait halts; insertion starts initialization
// [RULE7] insertion detection takes about 3 ms
// [RULE8] host command serviced, then back halted; addressed commands are ignored while halted
// [RULE9] low voltage after valid reading: rest
// [RULE10] current rest needs request, reading, low current
// [RULE11] rest until addressed command or power-on
// [RULE12] battery good negated during rest
// [RULE13] host wakes rest with addressed command
// [RULE14] host prefers doze while charger attached
// [RULE15] software reset classified and counted
// [RULE16] partial reset checks memory checksum
// [RULE17] wake comparator both directions; 00 disables
// [RULE18] select bits and range pick threshold
// [RULE19] nonvolatile writes only at sufficient voltage
// [RULE20] doze calibration skipped at temperature extremes; skipped only at or below 5 C or at exactly 45 C
// [RULE21] single calibration on voltage/temperature change
// [RULE22] calibration keeps accumulating, aborts on sag
// [RULE23] battery good after reading, polarity selectable
// [RULE24] normal default, one transition, removal first; the rest mode does not check removal
module gpm_top #(
  parameter int INSERT_CYCLES = gpm_pkg::INSERT_CYC,
  parameter int DOZE_PERIOD = gpm_pkg::DOZE_PERIOD_CYC,
  parameter int TEMP_PERSIST = gpm_pkg::TEMP_PERSIST_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic battery_present_pin,
  input wire logic ext_supply_pin,
  input wire logic addressed_cmd_pin,
  input wire logic signed [15:0] shunt_uv,
  output logic battery_good_output,
  output logic measure_strobe,
  output logic core_halted,
  output logic ocv_request,
  output logic flash_write_ok,
  output logic profile_select
);
  typedef struct packed {
    gpm_pkg::gpm_mode_t mode;
    logic [31:0] cfg;
    logic [15:0] doze_thr, rest_thr, flash_thr;
    logic signed [15:0] avg_i, volt, temp;
    logic rest_req, ocv_valid, cal_to_doze;
    logic [31:0] tmr;
    logic [31:0] tpers;
    logic [15:0] cal_v0, last_cal_v;
    logic signed [15:0] last_cal_t, offset;
    logic [7:0] cnt_full, cnt_part;
    logic [15:0] mem_sum, stored_sum;
    logic mem_reinit, prof;
    logic [1:0] bp_s, es_s, ac_s;
    logic [31:0] rdata;
    logic meas;
  } gpm_state_t;

  gpm_state_t s_q, s_d;

  function automatic logic [15:0] wake_thr(input logic [2:0] sel);
    unique case (sel)
      3'b010: wake_thr = gpm_pkg::VTH_1P0;
      3'b011, 3'b100: wake_thr = gpm_pkg::VTH_2P2;
      3'b101, 3'b110: wake_thr = gpm_pkg::VTH_4P6;
      3'b111: wake_thr = gpm_pkg::VTH_9P8;
      default: wake_thr = 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction

  logic setup, wr, rd, batt, ext, cmd, wake_hit, cal_ok, dv_big, cal_sag;
  logic [2:0] wsel;
  logic [15:0] wth;

  always_comb begin
    setup = psel && !penable;
    wr = psel && penable && pwrite;
    rd = setup && !pwrite;
    batt = s_q.bp_s[1];
    ext = s_q.es_s[1];
    cmd = s_q.ac_s[1];
    wsel = {s_q.cfg[gpm_pkg::CFG_SNS_HIGH], s_q.cfg[gpm_pkg::CFG_SNS_LOW],
            s_q.cfg[gpm_pkg::CFG_WAKE_RANGE]};
    wth = wake_thr(wsel); // [RULE18]
    // disabled when both select bits are zero [RULE17]
    wake_hit = (wsel[2:1] != 2'b00) && (mag(shunt_uv) > wth);
    cal_ok = !((s_q.temp <= gpm_pkg::T_LOW_C) ||
               (s_q.temp == gpm_pkg::T_SKIP_C)); // [RULE20]
    dv_big = mag(16'(s_q.volt - s_q.last_cal_v)) >= gpm_pkg::CAL_DV_MV;
    // signed so a rising voltage never reads as a large sag [RULE22]
    cal_sag = $signed(16'(s_q.cal_v0 - s_q.volt)) >
              $signed(gpm_pkg::CAL_ABORT_MV);
    s_d = s_q;
    s_d.meas = 1'b0;
    s_d.bp_s = {s_q.bp_s[0], battery_present_pin};
    s_d.es_s = {s_q.es_s[0], ext_supply_pin};
    s_d.ac_s = {s_q.ac_s[0], addressed_cmd_pin};
    if (s_q.temp != s_q.last_cal_t)
      s_d.tpers = s_q.tpers + 32'd1;
    else
      s_d.tpers = '0;
    if (rd) begin
      unique case (paddr)
        gpm_pkg::OFF_CONFIG: s_d.rdata = s_q.cfg;
        gpm_pkg::OFF_DOZE_THR: s_d.rdata = {16'h0000, s_q.doze_thr};
        gpm_pkg::OFF_REST_THR: s_d.rdata = {16'h0000, s_q.rest_thr};
        gpm_pkg::OFF_FLASH_THR: s_d.rdata = {16'h0000, s_q.flash_thr};
        gpm_pkg::OFF_MEAS_I: s_d.rdata = {16'h0000, s_q.avg_i};
        gpm_pkg::OFF_MEAS_V: s_d.rdata = {16'h0000, s_q.volt};
        gpm_pkg::OFF_MEAS_T: s_d.rdata = {16'h0000, s_q.temp};
        gpm_pkg::OFF_STATUS:
          s_d.rdata = {24'h00_0000, s_q.prof, s_q.ocv_valid,
                       s_q.rest_req, 2'b00, 3'(s_q.mode)};
        gpm_pkg::OFF_RST_CNT:
          s_d.rdata = {16'h0000, s_q.cnt_part, s_q.cnt_full}; // [RULE15]
        gpm_pkg::OFF_OFFSET: s_d.rdata = {16'h0000, s_q.offset};
        gpm_pkg::OFF_CHECKSUM: s_d.rdata = {16'h0000, s_q.stored_sum};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    s_d.mem_reinit = 1'b0;
    if (wr) begin
      unique case (paddr)
        gpm_pkg::OFF_CONFIG: s_d.cfg = pwdata;
        gpm_pkg::OFF_DOZE_THR: s_d.doze_thr = pwdata[15:0];
        gpm_pkg::OFF_REST_THR: s_d.rest_thr = pwdata[15:0];
        gpm_pkg::OFF_FLASH_THR: s_d.flash_thr = pwdata[15:0];
        gpm_pkg::OFF_MEAS_I: s_d.avg_i = pwdata[15:0];
        gpm_pkg::OFF_MEAS_V: s_d.volt = pwdata[15:0];
        gpm_pkg::OFF_MEAS_T: s_d.temp = pwdata[15:0];
        gpm_pkg::OFF_CONTROL: begin
          s_d.rest_req = pwdata[gpm_pkg::CTL_REST_REQ];
          if (pwdata[gpm_pkg::CTL_SW_RESET]) begin
            if (pwdata[gpm_pkg::CTL_RESET_PARTIAL]) begin
              s_d.cnt_part = s_q.cnt_part + 8'd1; // [RULE15]
              // mismatch forces full reinit [RULE16]
              if (s_q.mem_sum != s_q.stored_sum) begin
                s_d.mem_reinit = 1'b1;
                s_d.mem_sum = '0;
                s_d.stored_sum = '0;
              end
            end else begin
              s_d.cnt_full = s_q.cnt_full + 8'd1; // [RULE15]
              s_d.mem_sum = '0;
              s_d.stored_sum = '0;
            end
          end else if (pwdata[gpm_pkg::CTL_MEM_WRITE]) begin
            // stored sum tracks every memory change [RULE16]
            s_d.mem_sum = s_q.mem_sum + pwdata[31:16];
            s_d.stored_sum = s_q.mem_sum + pwdata[31:16];
          end
        end
        default: ;
      endcase
    end
    // one transition per evaluation, removal first in normal and calibration, not checked in rest [RULE24]
    unique case (s_q.mode)
      gpm_pkg::GPM_NORMAL: begin
        s_d.meas = 1'b1;
        if (!batt && ext) begin
          s_d.mode = gpm_pkg::GPM_INSERT_WAIT; // [RULE5]
          s_d.ocv_valid = 1'b0;
          s_d.tmr = '0;
        end else if (s_q.ocv_valid &&
                     16'(s_q.volt) < s_q.rest_thr) begin
          s_d.mode = gpm_pkg::GPM_REST; // [RULE9]
        end else if (s_q.rest_req && s_q.ocv_valid &&
                     mag(s_q.avg_i) < s_q.rest_thr) begin
          s_d.mode = gpm_pkg::GPM_REST; // [RULE10]
        end else if (s_q.cfg[gpm_pkg::CFG_DOZE_EN] &&
                     s_q.avg_i < $signed(s_q.doze_thr)) begin
          // [RULE1] qualified; calibrate before doze when cal_ok [RULE2]
          s_d.cal_to_doze = 1'b1;
          s_d.tmr = '0;
          s_d.cal_v0 = s_q.volt;
          s_d.mode = cal_ok ? gpm_pkg::GPM_CAL : gpm_pkg::GPM_DOZE;
        end else if (mag(s_q.avg_i) <= gpm_pkg::CAL_I_MAX_MA &&
                     (dv_big || s_q.tpers >= 32'(TEMP_PERSIST))) begin
          s_d.cal_to_doze = 1'b0; // [RULE21]
          s_d.tmr = '0;
          s_d.cal_v0 = s_q.volt;
          s_d.mode = gpm_pkg::GPM_CAL;
        end
      end
      gpm_pkg::GPM_CAL: begin
        // accumulation continues at last rate [RULE22]
        s_d.meas = 1'b1;
        s_d.tmr = s_q.tmr + 32'd1;
        if (!batt && ext) begin
          // removal must not wait for the calibration to finish
          s_d.mode = gpm_pkg::GPM_INSERT_WAIT; // [RULE5]
          s_d.ocv_valid = 1'b0;
          s_d.tmr = '0;
        end else if (cal_sag) begin
          s_d.mode = gpm_pkg::GPM_NORMAL; // [RULE22]
        end else if (s_q.tmr >= 32'(gpm_pkg::CAL_CYC - 1)) begin
          s_d.offset = shunt_uv; // [RULE20]
          s_d.last_cal_v = s_q.volt;
          s_d.last_cal_t = s_q.temp;
          s_d.tmr = '0;
          s_d.mode = s_q.cal_to_doze ? gpm_pkg::GPM_DOZE
                                     : gpm_pkg::GPM_NORMAL;
        end
      end
      gpm_pkg::GPM_DOZE: begin
        s_d.tmr = s_q.tmr + 32'd1;
        if (s_q.tmr >= 32'(DOZE_PERIOD - 1)) begin
          s_d.tmr = '0;
          s_d.meas = 1'b1; // [RULE3]
        end
        if ((!batt && ext) || s_q.avg_i > $signed(s_q.doze_thr) ||
            wake_hit)
          s_d.mode = gpm_pkg::GPM_NORMAL; // [RULE4]
      end
      gpm_pkg::GPM_INSERT_WAIT: begin
        // addressed command ignored; core stays halted until insertion [RULE8]
        if (batt) begin
          s_d.tmr = s_q.tmr + 32'd1;
          if (s_q.tmr >= 32'(INSERT_CYCLES - 1)) begin
            s_d.tmr = '0;
            s_d.mode = gpm_pkg::GPM_INIT; // [RULE7]
          end
        end else begin
          s_d.tmr = '0;
        end
      end
      gpm_pkg::GPM_INIT: begin
        // ocv taken, good asserted, profile chosen [RULE6]
        s_d.ocv_valid = 1'b1;
        s_d.prof = !s_q.prof;
        s_d.mode = gpm_pkg::GPM_NORMAL;
      end
      gpm_pkg::GPM_REST: begin
        if (cmd) begin
          s_d.ocv_valid = 1'b0; // [RULE11] [RULE13]
          s_d.rest_req = 1'b0;
          s_d.mode = gpm_pkg::GPM_INIT;
        end
      end
      default: s_d.mode = gpm_pkg::GPM_NORMAL;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.cfg <= gpm_pkg::CONFIG_RST;
      s_q.doze_thr <= gpm_pkg::DOZE_THR_RST;
      s_q.rest_thr <= gpm_pkg::REST_THR_RST;
      s_q.flash_thr <= gpm_pkg::FLASH_THR_RST;
      s_q.mode <= gpm_pkg::GPM_INSERT_WAIT;
    end else begin
      s_q <= s_d;
    end
  end

  logic good_int;
  always_comb begin
    pready = 1'b1;
    pslverr = 1'b0;
    prdata = s_q.rdata;
    // negated in rest and before reading [RULE12] [RULE23]
    good_int = s_q.ocv_valid && (s_q.mode != gpm_pkg::GPM_REST);
    battery_good_output = good_int ~^ s_q.cfg[gpm_pkg::CFG_GOOD_POL];
    measure_strobe = s_q.meas;
    core_halted = (s_q.mode == gpm_pkg::GPM_INSERT_WAIT); // [RULE6]
    ocv_request = (s_q.mode == gpm_pkg::GPM_INIT);
    flash_write_ok = 16'(s_q.volt) >= s_q.flash_thr; // [RULE19]
    profile_select = s_q.prof;
  end

  sequence ins_absent;
    s_q.mode == gpm_pkg::GPM_INSERT_WAIT && !s_q.bp_s[1];
  endsequence

  chk_doze_entry: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode != gpm_pkg::GPM_NORMAL && $past(s_q.mode) ==
     gpm_pkg::GPM_NORMAL && (s_q.mode == gpm_pkg::GPM_DOZE ||
     s_q.cal_to_doze && s_q.mode == gpm_pkg::GPM_CAL)) |->
    $past(s_q.cfg[gpm_pkg::CFG_DOZE_EN]))
    else $error("doze entered while disabled"); // [RULE1]
  chk_rest_good: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.mode == gpm_pkg::GPM_REST |->
    battery_good_output == !s_q.cfg[gpm_pkg::CFG_GOOD_POL])
    else $error("battery good asserted in rest"); // [RULE12]
  chk_flash_gate: assert property (@(posedge pclk) disable iff (!presetn)
    flash_write_ok == (16'(s_q.volt) >= s_q.flash_thr))
    else $error("flash gate wrong"); // [RULE19]
  chk_removal_exit: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode == gpm_pkg::GPM_NORMAL && !s_q.bp_s[1] && s_q.es_s[1])
    |=> s_q.mode == gpm_pkg::GPM_INSERT_WAIT)
    else $error("removal not handled"); // [RULE5]
  chk_insert_time: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode == gpm_pkg::GPM_INSERT_WAIT ##1
     s_q.mode == gpm_pkg::GPM_INIT) |-> $past(s_q.tmr, 1) ==
     32'(INSERT_CYCLES - 1))
    else $error("insertion timing wrong"); // [RULE7]
  chk_init_good: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.mode == gpm_pkg::GPM_INIT |=> s_q.ocv_valid ##0
    s_q.mode == gpm_pkg::GPM_NORMAL)
    else $error("init did not complete"); // [RULE6]
  chk_rest_stay: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode == gpm_pkg::GPM_REST && !s_q.ac_s[1]) |=>
    s_q.mode == gpm_pkg::GPM_REST)
    else $error("rest left without command"); // [RULE11]
  chk_wake_exit: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode == gpm_pkg::GPM_DOZE && wake_hit) |=>
    s_q.mode == gpm_pkg::GPM_NORMAL)
    else $error("wake ignored in doze"); // [RULE4]
  chk_wake_off: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode == gpm_pkg::GPM_DOZE && wsel[2:1] == 2'b00 &&
     s_q.avg_i <= $signed(s_q.doze_thr) &&
     !(!s_q.bp_s[1] && s_q.es_s[1])) |=> s_q.mode == gpm_pkg::GPM_DOZE)
    else $error("comparator not disabled"); // [RULE17]
  chk_cal_abort: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode == gpm_pkg::GPM_CAL &&
     s_q.bp_s[1] && cal_sag) |=>
    s_q.mode == gpm_pkg::GPM_NORMAL)
    else $error("calibration not aborted"); // [RULE22]
  chk_halt_ins: assert property (@(posedge pclk) disable iff (!presetn)
    ins_absent |=> core_halted)
    else $error("halt left without battery"); // [RULE8]
endmodule
